// ---- hdl/pin_sync.sv ----
// three-stage synchroniser; output moves once stages two and three agree
`timescale 1ns/1ps
module pin_sync (
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic reset_n_i,
	// async pin in, clean level out
	input  wire logic pin_i,
	output logic      level_o
);
	logic s1_q, s2_q, s3_q, level_q;
	logic level_d;

	// hold last agreed value while stages disagree
	always_comb begin
		level_d = level_q;
		if (s2_q == s3_q) begin
			level_d = s3_q;
		end
	end

	// register chain
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_q    <= 1'b0;
			s2_q    <= 1'b0;
			s3_q    <= 1'b0;
			level_q <= 1'b0;
		end else begin
			s1_q    <= pin_i;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			level_q <= level_d;
		end
	end

	assign level_o = level_q;
endmodule

// ---- hdl/run_ready_pkg.sv ----
// shared constants and carrier types for the run/ready status logic
package run_ready_pkg;
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned BLINK_PERIOD_MS = 1000;
	// half period in cycles: period in ms times cycles per ms, halved
	localparam int unsigned BLINK_HALF_CYC = (BLINK_PERIOD_MS * (CLK_HZ / 1000)) / 2;
	localparam int unsigned BLINK_CNT_W   = 26;
	localparam logic [BLINK_CNT_W-1:0] BLINK_CNT_ZERO = 26'h0;
	localparam logic [BLINK_CNT_W-1:0] BLINK_CNT_ONE  = 26'h1;
	// ready relay output levels
	localparam logic RELAY_READY     = 1'b1;
	localparam logic RELAY_NOT_READY = 1'b0;

	// panel switch and remote inputs, raw from pins
	typedef struct packed {
		logic start_sw;
		logic stop_sw;
		logic remote_start;
	} start_pins_t;

	// conditions reported by the surrounding system
	typedef struct packed {
		logic method_loaded;
		logic in_run;
		logic seq_mode;
		logic seq_done;
		logic mem_ok;
		logic seg_free;
		logic panel_enabled;
	} rearm_cond_t;

	// indicator drive
	typedef struct packed {
		logic system_ready;
		logic ready_active;
		logic range_error;
	} leds_t;

	typedef enum logic [1:0] {
		OVR_NONE,
		OVR_FORCE_READY,
		OVR_FORCE_NOT_READY
	} override_t;
endpackage

// ---- hdl/run_ready_status_logic.sv ----
// run arming, start gating, ready relay and front panel indicator control
`timescale 1ns/1ps
module run_ready_status_logic #(
	// blink half period in clock cycles
	parameter int unsigned BLINK_HALF = run_ready_pkg::BLINK_HALF_CYC
) (
	// clock and reset
	input  wire logic                        core_clk_i,
	input  wire logic                        reset_n_i,
	// raw pins: panel switches and remote start
	input  wire run_ready_pkg::start_pins_t  pins_i,
	// system conditions, same clock domain
	input  wire run_ready_pkg::rearm_cond_t  cond_i,
	input  wire logic                        fw_online_i,
	input  wire logic                        data_backlog_i,
	input  wire logic                        out_of_range_i,
	input  wire logic                        adc_cmd_error_i,
	// outputs
	output logic                             start_run_o,
	output logic                             ready_relay_o,
	output logic                             armed_o,
	output run_ready_pkg::leds_t             leds_o
);
	// synchronised pin levels
	logic start_lvl, stop_lvl, remote_lvl;

	pin_sync u_sync_start (
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.pin_i      (pins_i.start_sw),
		.level_o    (start_lvl)
	);
	pin_sync u_sync_stop (
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.pin_i      (pins_i.stop_sw),
		.level_o    (stop_lvl)
	);
	pin_sync u_sync_remote (
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.pin_i      (pins_i.remote_start),
		.level_o    (remote_lvl)
	);

	// state
	logic                                  start_prev_q, remote_prev_q, loaded_prev_q, run_prev_q;
	logic                                  ready_q, ready_d;
	logic                                  acq_q, acq_d;
	run_ready_pkg::override_t              ovr_q, ovr_d;
	logic                                  start_q, start_d;
	logic                                  relay_q, relay_d;
	run_ready_pkg::leds_t                  leds_q, leds_d;
	logic [run_ready_pkg::BLINK_CNT_W-1:0] blink_cnt_q, blink_cnt_d;
	logic                                  blink_q, blink_d;

	// rising edge of a level against its registered copy
	function automatic logic rose_edge(input logic now_lvl, input logic prev_lvl);
		return now_lvl & ~prev_lvl;
	endfunction

	// ready as shown on relay and indicator: effectively ready and idle
	function automatic logic shown_ready(input logic ready_lvl, input logic busy);
		return ready_lvl & ~busy;
	endfunction

	// edge events on synchronised pin levels and on the method-loaded and in-run conditions
	logic start_rise, remote_rise, toggle_ev, panel_start, loaded_rise, run_end;
	logic rearm_ok, eff_ready;

	assign start_rise  = rose_edge(start_lvl, start_prev_q);
	assign remote_rise = rose_edge(remote_lvl, remote_prev_q);
	assign loaded_rise = rose_edge(cond_i.method_loaded, loaded_prev_q);
	assign run_end     = rose_edge(run_prev_q, cond_i.in_run);  // in-run seen, now dropped
	assign toggle_ev   = start_rise & stop_lvl;
	assign panel_start = start_rise & ~stop_lvl;

	// all re-arm conditions
	assign rearm_ok = ~cond_i.in_run
		& (~cond_i.seq_mode | ~cond_i.seq_done)
		& cond_i.mem_ok
		& cond_i.seg_free
		& cond_i.panel_enabled;

	// override wins over normal ready tracking
	always_comb begin
		unique case (ovr_q)
			run_ready_pkg::OVR_FORCE_READY:     eff_ready = 1'b1;
			run_ready_pkg::OVR_FORCE_NOT_READY: eff_ready = 1'b0;
			run_ready_pkg::OVR_NONE:            eff_ready = ready_q;
			default:                            eff_ready = 1'b0;  // unused code: not ready
		endcase
	end

	// blink timebase: fixed period from the clock only
	always_comb begin
		blink_cnt_d = blink_cnt_q + run_ready_pkg::BLINK_CNT_ONE;
		blink_d     = blink_q;
		// wrap and flip the phase once a half period is complete
		if (blink_cnt_d == run_ready_pkg::BLINK_CNT_W'(BLINK_HALF)) begin
			blink_cnt_d = run_ready_pkg::BLINK_CNT_ZERO;
			blink_d     = ~blink_q;
		end
	end

	// ready / acquisition / override sequencing
	always_comb begin
		ready_d = ready_q;
		acq_d   = acq_q;
		ovr_d   = ovr_q;
		start_d = 1'b0;
		// toggle forced state; first toggle forces ready
		if (toggle_ev) begin
			unique case (ovr_q)
				run_ready_pkg::OVR_FORCE_READY: ovr_d = run_ready_pkg::OVR_FORCE_NOT_READY;
				run_ready_pkg::OVR_FORCE_NOT_READY: ovr_d = run_ready_pkg::OVR_FORCE_READY;
				run_ready_pkg::OVR_NONE: ovr_d = run_ready_pkg::OVR_FORCE_READY;
				default: ovr_d = run_ready_pkg::OVR_NONE;
			endcase
		end
		// run ends once the system has reported it and then drops in-run
		if (acq_q && run_end) begin
			acq_d = 1'b0;
		end
		// arm on method load, re-arm after run when allowed
		if (!acq_q && !ready_q && cond_i.method_loaded && (loaded_rise || rearm_ok)) begin
			ready_d = rearm_ok | loaded_rise;
		end
		// start only when effectively ready
		if (eff_ready && !acq_q && !toggle_ev && (panel_start || remote_rise)) begin
			start_d = 1'b1;
			acq_d   = 1'b1;
			ready_d = 1'b0;
		end
	end

	// relay and indicator drive
	always_comb begin
		relay_d = shown_ready(eff_ready, acq_q) ? run_ready_pkg::RELAY_READY
			: run_ready_pkg::RELAY_NOT_READY;
		leds_d.ready_active = acq_q ? blink_q : shown_ready(eff_ready, acq_q);
		if (!fw_online_i) begin
			leds_d.system_ready = 1'b0;
		end else if (data_backlog_i && !acq_q) begin
			leds_d.system_ready = blink_q;
		end else begin
			leds_d.system_ready = 1'b1;
		end
		// command error blink outranks out-of-range
		if (adc_cmd_error_i) begin
			leds_d.range_error = blink_q;
		end else begin
			leds_d.range_error = out_of_range_i;
		end
	end

	// edge history of the watched levels
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			start_prev_q  <= 1'b0;
			remote_prev_q <= 1'b0;
			loaded_prev_q <= 1'b0;
			run_prev_q    <= 1'b0;
		end else begin
			start_prev_q  <= start_lvl;
			remote_prev_q <= remote_lvl;
			loaded_prev_q <= cond_i.method_loaded;
			run_prev_q    <= cond_i.in_run;
		end
	end

	// blink timebase registers
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			blink_cnt_q   <= run_ready_pkg::BLINK_CNT_ZERO;
			blink_q       <= 1'b0;
		end else begin
			blink_cnt_q   <= blink_cnt_d;
			blink_q       <= blink_d;
		end
	end

	// ready, acquisition and override registers
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ready_q       <= 1'b0;
			acq_q         <= 1'b0;
			ovr_q         <= run_ready_pkg::OVR_NONE;
			start_q       <= 1'b0;
		end else begin
			ready_q       <= ready_d;
			acq_q         <= acq_d;
			ovr_q         <= ovr_d;
			start_q       <= start_d;
		end
	end

	// relay and indicator registers
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			relay_q       <= run_ready_pkg::RELAY_NOT_READY;
			leds_q        <= '0;
		end else begin
			relay_q       <= relay_d;
			leds_q        <= leds_d;
		end
	end

	assign start_run_o   = start_q;
	assign ready_relay_o = relay_q;
	assign armed_o       = ready_q;
	assign leds_o        = leds_q;
endmodule

// ---- verification/panel_model.sv ----
// operator panel switches and remote start line
`timescale 1ns/1ps
module panel_model (
	// clock
	input  wire logic                  core_clk_i,
	// pin levels toward the block
	output run_ready_pkg::start_pins_t pins_o
);
	initial pins_o = 3'h0;
	// set pin levels after an edge, hold them n clocks
	task automatic hold(input run_ready_pkg::start_pins_t p, input int n);
		@(posedge core_clk_i);
		pins_o <= p;
		repeat (n) @(posedge core_clk_i);
	endtask
	// panel start tap
	task automatic tap_start();
		hold(3'h4, 8);
		hold(3'h0, 8);
	endtask
	// start tapped with stop held
	task automatic toggle_override();
		hold(3'h2, 8);
		hold(3'h6, 8);
		hold(3'h2, 8);
		hold(3'h0, 8);
	endtask
	// remote start pulse
	task automatic remote();
		hold(3'h1, 8);
		hold(3'h0, 8);
	endtask
endmodule

// ---- verification/run_ready_sva.sv ----
// assertions on the run/ready status logic ports
`timescale 1ns/1ps
module run_ready_sva (
	// clock and reset
	input wire logic                       core_clk_i,
	input wire logic                       reset_n_i,
	// watched inputs
	input wire run_ready_pkg::rearm_cond_t cond_i,
	input wire logic                       fw_online_i,
	input wire logic                       out_of_range_i,
	input wire logic                       adc_cmd_error_i,
	// watched outputs
	input wire logic                       start_run_o,
	input wire logic                       ready_relay_o,
	input wire logic                       armed_o,
	input wire run_ready_pkg::leds_t       leds_o
);
	logic rearm_ok;
	// every re-arm condition at once
	assign rearm_ok = !cond_i.in_run && !(cond_i.seq_mode && cond_i.seq_done) &&
		cond_i.mem_ok && cond_i.seg_free && cond_i.panel_enabled;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	chk_reset_dark: assert property (
		$rose(reset_n_i) |-> !ready_relay_o && !leds_o.ready_active)
		else $error("outputs lit after reset");
	chk_arm_load: assert property (
		$rose(cond_i.method_loaded) |=> armed_o)
		else $error("no arm after method load");
	chk_led_tracks: assert property (
		$rose(ready_relay_o) |-> leds_o.ready_active)
		else $error("ready led off while relay ready");
	chk_start_gate: assert property (
		start_run_o |-> $past(ready_relay_o))
		else $error("start while not ready");
	chk_start_drop: assert property (
		start_run_o |=> !armed_o && !start_run_o)
		else $error("still armed after start");
	chk_rearm_cond: assert property (
		$rose(armed_o) && $past(cond_i.method_loaded, 2) |-> $past(rearm_ok))
		else $error("re-armed without conditions");
	chk_sys_dark: assert property (
		!fw_online_i |=> !leds_o.system_ready)
		else $error("system led lit without firmware");
	chk_range_on: assert property (
		out_of_range_i && !adc_cmd_error_i |=> leds_o.range_error)
		else $error("range led dark out of range");
endmodule
bind run_ready_status_logic run_ready_sva chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
	.cond_i(cond_i), .fw_online_i(fw_online_i), .out_of_range_i(out_of_range_i),
	.adc_cmd_error_i(adc_cmd_error_i), .start_run_o(start_run_o),
	.ready_relay_o(ready_relay_o), .armed_o(armed_o), .leds_o(leds_o));

// ---- verification/tb_top.sv ----
// testbench: reset, arming, start gating, override and indicators
`timescale 1ns/1ps
module tb_top;
	logic core_clk_i, start_run_o, ready_relay_o, armed_o;
	logic reset_n_i = 1'h0, fw_online_i = 1'h0, data_backlog_i = 1'h0;
	logic out_of_range_i = 1'h0, adc_cmd_error_i = 1'h0;
	run_ready_pkg::start_pins_t pins_i;
	run_ready_pkg::rearm_cond_t cond_i = 7'h07;
	run_ready_pkg::leds_t       leds_o;
	int fail_count = 0, comparisons = 0, starts = 0;
	// each entry lacks one re-arm condition
	localparam run_ready_pkg::rearm_cond_t blocked [4] = '{7'h43, 7'h45, 7'h46, 7'h5f};
	localparam int unsigned blink_half = 4;  // short blink so rates fit the run
	run_ready_status_logic #(.BLINK_HALF(blink_half)) dut (.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i), .pins_i(pins_i),
		.cond_i(cond_i), .fw_online_i(fw_online_i), .data_backlog_i(data_backlog_i),
		.out_of_range_i(out_of_range_i), .adc_cmd_error_i(adc_cmd_error_i),
		.start_run_o(start_run_o), .ready_relay_o(ready_relay_o), .armed_o(armed_o),
		.leds_o(leds_o));
	panel_model panel (.core_clk_i(core_clk_i), .pins_o(pins_i));
	// clock
	initial begin
		core_clk_i = 1'h0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	// count start pulses
	always @(posedge core_clk_i) if (start_run_o === 1'h1) starts++;
	// compare and count
	task automatic check(input logic got, input logic exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	// count indicator changes over 32 cycles against the expected number
	task automatic toggles(input int idx, input int exp, input string msg);
		logic last;
		int   n;
		n    = 0;
		last = leds_o[idx];
		repeat (32) begin
			@(posedge core_clk_i);
			if (leds_o[idx] !== last) n++;
			last = leds_o[idx];
		end
		check(n == exp, 1'h1, msg);
	endtask
	// host side: new conditions, then wait
	task automatic host(input run_ready_pkg::rearm_cond_t c, input int n);
		@(posedge core_clk_i);
		cond_i <= c;
		repeat (n) @(posedge core_clk_i);
	endtask
	// counts and verdict
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (3000) @(posedge core_clk_i);
		fail_count++;
		report_and_stop();
	end
	// main sequence
	initial begin
		repeat (12) @(posedge core_clk_i);
		reset_n_i <= 1'h1;
		repeat (2) @(posedge core_clk_i);
		check(ready_relay_o | leds_o.ready_active, 1'h0, "lit after reset");
		panel.tap_start();
		panel.remote();
		check(starts == 0, 1'h1, "start while not ready");
		host(7'h47, 3);
		check(ready_relay_o & leds_o.ready_active, 1'h1, "not ready after load");
		panel.tap_start();
		check(starts == 1 && !ready_relay_o, 1'h1, "start or relay drop");
		host(7'h67, 5);
		panel.remote();
		foreach (blocked[i]) begin
			host(blocked[i], 8);
			check(armed_o, 1'h0, "re-armed too early");
		end
		host(7'h47, 3);
		check(armed_o & ready_relay_o && starts == 1, 1'h1, "re-arm");
		panel.toggle_override();
		check(starts == 1 && ready_relay_o, 1'h1, "forced ready");
		panel.toggle_override();
		check(ready_relay_o, 1'h0, "forced not ready");
		panel.tap_start();
		check(starts == 1, 1'h1, "start while forced off");
		panel.toggle_override();
		panel.remote();
		check(starts == 2, 1'h1, "no start while forced on");
		check(leds_o.system_ready, 1'h0, "system led without firmware");
		@(posedge core_clk_i);
		fw_online_i <= 1'h1;
		out_of_range_i <= 1'h1;
		repeat (3) @(posedge core_clk_i);
		check(leds_o.system_ready, 1'h1, "system led dark");
		check(leds_o.range_error, 1'h1, "range led dark");
		toggles(1, 32 / blink_half, "ready led rate in run");
		data_backlog_i <= 1'h1;
		adc_cmd_error_i <= 1'h1;
		repeat (3) @(posedge core_clk_i);
		toggles(2, 0, "system led blinks in run");
		toggles(0, 32 / blink_half, "error led not blinking");
		host(7'h67, 3);
		host(7'h47, 3);
		toggles(2, 32 / blink_half, "backlog led steady");
		report_and_stop();
	end
endmodule
